// File: verilog/shift_move_indirect_pkg.sv
// shared constants and types for the shift, move and indirect-load unit
package shift_move_indirect_pkg;

    // ========================================================
    // register byte offsets
    localparam logic [11:0] CMD_OFFSET = 12'h000;
    localparam logic [11:0] ACC_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;
    localparam logic [11:0] PTR0_OFFSET = 12'h00C;
    localparam logic [11:0] PTR1_OFFSET = 12'h010;
    localparam logic [11:0] MEM_BASE = 12'h100;

    // ========================================================
    // command word fields
    localparam int FILE_POS = 0;
    localparam int FILE_W = 7;
    localparam int DEST_POS = 7;
    localparam int OP_POS = 8;
    localparam int MODE_POS = 10;
    localparam int SEL_POS = 12;
    localparam int REL_POS = 13;
    localparam int OFFS_POS = 14;
    localparam int OFFS_W = 6;

    // ========================================================
    // status fields
    localparam int CARRY_POS = 0;
    localparam int ZERO_POS = 1;

    // ========================================================
    // file addresses that open the indirect data window
    localparam logic [6:0] WINDOW0_FILE = 7'h00;
    localparam logic [6:0] WINDOW1_FILE = 7'h01;

    // ========================================================
    // reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [7:0] MEM_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;

    // ========================================================
    // operations and pointer update modes
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        LOGICAL_SHIFT_RIGHT_OP = 2'b01,
        FILE_MOVE_OP = 2'b10,
        INDIRECT_LOAD_OP = 2'b11
    } op_t;

    typedef enum logic [1:0] {
        PRE_INC = 2'b00,
        PRE_DEC = 2'b01,
        POST_INC = 2'b10,
        POST_DEC = 2'b11
    } pointer_update_mode_t;

endpackage

// File: verilog/pointer_step.sv
// effective address and updated value of one file select pointer
module pointer_step (
    input wire logic [15:0] ptr_in,
    input wire shift_move_indirect_pkg::pointer_update_mode_t mode_in,
    input wire logic relative_in,
    input wire logic [5:0] offset_in,
    output logic [15:0] eff_addr_out,
    output logic [15:0] next_ptr_out
);
    logic [15:0] inc;
    logic [15:0] dec;
    logic [15:0] offs_ext;

    // 16-bit sums wrap past FFFF and below 0000 by themselves
    assign inc = ptr_in + 16'h0001; // RULE12
    assign dec = ptr_in - 16'h0001; // RULE12
    assign offs_ext = {{10{offset_in[5]}}, offset_in};

    always_comb begin
        eff_addr_out = ptr_in;
        next_ptr_out = ptr_in;
        if (relative_in) begin
            eff_addr_out = ptr_in + offs_ext; // RULE6
            next_ptr_out = ptr_in; // RULE7
        end else begin
            unique case (mode_in) // RULE8
                shift_move_indirect_pkg::PRE_INC: begin
                    eff_addr_out = inc; // RULE6
                    next_ptr_out = inc; // RULE7
                end
                shift_move_indirect_pkg::PRE_DEC: begin
                    eff_addr_out = dec; // RULE6
                    next_ptr_out = dec; // RULE7
                end
                shift_move_indirect_pkg::POST_INC: begin
                    eff_addr_out = ptr_in; // RULE6
                    next_ptr_out = inc; // RULE7
                end
                shift_move_indirect_pkg::POST_DEC: begin
                    eff_addr_out = ptr_in; // RULE6
                    next_ptr_out = dec; // RULE7
                end
            endcase
        end
    end
endmodule // pointer_step

// File: verilog/shift_move_indirect_exec.sv
// execution unit for right shift, file move and indirect load, APB slave
// How it works
// RULE1: the shift writes 0 to bit 7, source bits 7..1 to bits 6..0, bit 0 to carry.
// RULE2: with destination bit 0 the shift result goes to the accumulator, else back to the file.
// RULE3: the shift sets zero when its result is zero and clears it otherwise.
// RULE4: the file move copies the file unchanged to the accumulator or back into itself.
// RULE5: the file move updates zero from the moved value, leaving the accumulator alone when d is 1.
// RULE6: the indirect load reads the byte at pointer+1, pointer-1, pointer or pointer+offset.
// RULE7: afterwards the pointer is +1 for increments, -1 for decrements, unchanged for offsets.
// RULE8: mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec; one index bit picks the pointer.
// RULE9: the indirect data windows are not storage of their own.
// RULE10: naming a window file reads or writes the location held in its pointer.
// RULE11: the indirect load sets zero when the loaded byte is zero, else clears it.
// RULE12: the sixteen-bit pointer wraps modulo its range.
// RULE13: the pointer arithmetic leaves carry and zero untouched.
module shift_move_indirect_exec #(
    parameter int DEPTH = 64
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic [7:0] acc_out,
    output logic carry_out,
    output logic zero_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [7:0] acc;
        logic carry;
        logic zero;
        logic [1:0][15:0] ptr;
        logic [DEPTH-1:0][7:0] mem;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } state_t;

    state_t s;
    state_t next_s;

    // ========================================================
    // command decode
    logic [6:0] file_addr;
    logic dest_file;
    shift_move_indirect_pkg::op_t op;
    shift_move_indirect_pkg::pointer_update_mode_t mode;
    logic ptr_sel;
    logic relative;
    logic [5:0] offset;
    logic [15:0] eff_addr;
    logic [15:0] next_ptr;
    logic [AW-1:0] file_idx;
    logic [AW-1:0] ind_idx;
    logic [7:0] file_val;
    logic [7:0] shifted;
    logic [7:0] loaded;

    assign file_addr = pwdata_in[shift_move_indirect_pkg::FILE_POS +:
        shift_move_indirect_pkg::FILE_W];
    assign dest_file = pwdata_in[shift_move_indirect_pkg::DEST_POS];
    assign op = shift_move_indirect_pkg::op_t'(
        pwdata_in[shift_move_indirect_pkg::OP_POS +: 2]);
    assign mode = shift_move_indirect_pkg::pointer_update_mode_t'(
        pwdata_in[shift_move_indirect_pkg::MODE_POS +: 2]); // RULE8
    assign ptr_sel = pwdata_in[shift_move_indirect_pkg::SEL_POS]; // RULE8
    assign relative = pwdata_in[shift_move_indirect_pkg::REL_POS];
    assign offset = pwdata_in[shift_move_indirect_pkg::OFFS_POS +:
        shift_move_indirect_pkg::OFFS_W];

    pointer_step u_step (
        .ptr_in(s.ptr[ptr_sel]),
        .mode_in(mode),
        .relative_in(relative),
        .offset_in(offset),
        .eff_addr_out(eff_addr),
        .next_ptr_out(next_ptr)
    );

    // window files hold nothing: they redirect through the pointer
    always_comb begin
        if (file_addr == shift_move_indirect_pkg::WINDOW0_FILE) begin
            file_idx = s.ptr[0][AW-1:0]; // RULE9 RULE10
        end else if (file_addr == shift_move_indirect_pkg::WINDOW1_FILE) begin
            file_idx = s.ptr[1][AW-1:0]; // RULE9 RULE10
        end else begin
            file_idx = AW'(file_addr);
        end
    end

    // memory wider than DEPTH aliases: only the low address bits count
    assign ind_idx = eff_addr[AW-1:0]; // RULE6
    assign file_val = s.mem[file_idx];
    assign shifted = {1'b0, file_val[7:1]}; // RULE1
    assign loaded = s.mem[ind_idx]; // RULE6 RULE10

    // ========================================================
    // bus decode
    logic access;
    logic commit;
    logic mem_hit;
    logic [AW-1:0] mem_idx;
    logic [11:0] mem_off;
    logic addr_err;
    logic [31:0] rdata;

    assign access = psel_in && penable_in;
    assign commit = access && s.pready && !s.pslverr && pwrite_in;
    assign mem_off = paddr_in - shift_move_indirect_pkg::MEM_BASE;
    assign mem_hit = (paddr_in >= shift_move_indirect_pkg::MEM_BASE) &&
        (mem_off < 12'(4 * DEPTH)) && (paddr_in[1:0] == 2'b00);
    assign mem_idx = mem_off[AW+1:2];

    always_comb begin
        rdata = 32'h0000_0000;
        addr_err = 1'b0;
        if (mem_hit) begin
            rdata = {24'h00_0000, s.mem[mem_idx]};
        end else begin
            unique case (paddr_in)
                shift_move_indirect_pkg::CMD_OFFSET: rdata = 32'h0000_0000;
                shift_move_indirect_pkg::ACC_OFFSET: begin
                    rdata = {24'h00_0000, s.acc};
                end
                shift_move_indirect_pkg::STATUS_OFFSET: begin
                    rdata = {30'h0000_0000, s.zero, s.carry};
                end
                shift_move_indirect_pkg::PTR0_OFFSET: begin
                    rdata = {16'h0000, s.ptr[0]};
                end
                shift_move_indirect_pkg::PTR1_OFFSET: begin
                    rdata = {16'h0000, s.ptr[1]};
                end
                default: addr_err = 1'b1;
            endcase
        end
    end

    // ========================================================
    // next state
    always_comb begin
        next_s = s;
        // one wait state lets prdata and pready leave flip-flops
        if (access && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.prdata = pwrite_in ? 32'h0000_0000 : rdata;
            next_s.pslverr = addr_err;
        end else begin
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
        end
        if (commit && mem_hit) begin
            next_s.mem[mem_idx] = pwdata_in[7:0];
        end else if (commit) begin
            unique case (paddr_in)
                shift_move_indirect_pkg::ACC_OFFSET: begin
                    next_s.acc = pwdata_in[7:0];
                end
                shift_move_indirect_pkg::STATUS_OFFSET: begin
                    next_s.carry = pwdata_in[shift_move_indirect_pkg::CARRY_POS];
                    next_s.zero = pwdata_in[shift_move_indirect_pkg::ZERO_POS];
                end
                shift_move_indirect_pkg::PTR0_OFFSET: begin
                    next_s.ptr[0] = pwdata_in[15:0];
                end
                shift_move_indirect_pkg::PTR1_OFFSET: begin
                    next_s.ptr[1] = pwdata_in[15:0];
                end
                shift_move_indirect_pkg::CMD_OFFSET: begin
                    unique case (op)
                        shift_move_indirect_pkg::OP_NONE: begin
                        end
                        shift_move_indirect_pkg::LOGICAL_SHIFT_RIGHT_OP: begin
                            if (dest_file) begin
                                next_s.mem[file_idx] = shifted; // RULE2
                            end else begin
                                next_s.acc = shifted; // RULE2
                            end
                            next_s.carry = file_val[0]; // RULE1
                            next_s.zero = (shifted == 8'h00); // RULE3
                        end
                        shift_move_indirect_pkg::FILE_MOVE_OP: begin
                            if (!dest_file) begin
                                next_s.acc = file_val; // RULE4
                            end
                            next_s.zero = (file_val == 8'h00); // RULE5
                        end
                        shift_move_indirect_pkg::INDIRECT_LOAD_OP: begin
                            next_s.acc = loaded; // RULE6
                            next_s.ptr[ptr_sel] = next_ptr; // RULE7 RULE12
                            // carry kept: pointer math is not the ALU
                            next_s.zero = (loaded == 8'h00); // RULE11 RULE13
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s.acc <= shift_move_indirect_pkg::ACC_RESET;
            s.carry <= shift_move_indirect_pkg::FLAG_RESET;
            s.zero <= shift_move_indirect_pkg::FLAG_RESET;
            s.ptr <= {2{shift_move_indirect_pkg::PTR_RESET}};
            s.mem <= {DEPTH{shift_move_indirect_pkg::MEM_RESET}};
            s.pready <= 1'b0;
            s.prdata <= 32'h0000_0000;
            s.pslverr <= 1'b0;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign prdata_out = s.prdata;
    assign pready_out = s.pready;
    assign pslverr_out = s.pslverr;
    assign acc_out = s.acc;
    assign carry_out = s.carry;
    assign zero_out = s.zero;

    // ========================================================
    // checks
    logic exec;
    assign exec = ce_in && commit &&
        (paddr_in == shift_move_indirect_pkg::CMD_OFFSET);

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_shift_bits;
        exec && op == shift_move_indirect_pkg::LOGICAL_SHIFT_RIGHT_OP &&
            !dest_file |=> s.acc == {1'b0, $past(file_val[7:1])} &&
            s.carry == $past(file_val[0]);
    endproperty
    a_shift_bits: assert property (p_shift_bits) // RULE1
        else $error("shift result or carry wrong");

    property p_shift_dest;
        exec && op == shift_move_indirect_pkg::LOGICAL_SHIFT_RIGHT_OP &&
            dest_file |=> s.acc == $past(s.acc) &&
            s.mem[$past(file_idx)] == {1'b0, $past(file_val[7:1])};
    endproperty
    a_shift_dest: assert property (p_shift_dest) // RULE2
        else $error("shift written to wrong destination");

    property p_shift_zero;
        exec && op == shift_move_indirect_pkg::LOGICAL_SHIFT_RIGHT_OP |=>
            s.zero == ($past(file_val[7:1]) == 7'h00);
    endproperty
    a_shift_zero: assert property (p_shift_zero) // RULE3
        else $error("shift zero flag wrong");

    property p_move_acc;
        exec && op == shift_move_indirect_pkg::FILE_MOVE_OP && !dest_file
            |=> s.acc == $past(file_val) && s.carry == $past(s.carry);
    endproperty
    a_move_acc: assert property (p_move_acc) // RULE4
        else $error("file move to accumulator wrong");

    property p_move_test;
        exec && op == shift_move_indirect_pkg::FILE_MOVE_OP && dest_file
            |=> s.acc == $past(s.acc) && s.zero == ($past(file_val) == 8'h00)
            && s.mem[$past(file_idx)] == $past(file_val);
    endproperty
    a_move_test: assert property (p_move_test) // RULE5
        else $error("file move zero test wrong");

    property p_ind_load;
        exec && op == shift_move_indirect_pkg::INDIRECT_LOAD_OP |=>
            s.acc == $past(s.mem[ind_idx]) &&
            s.zero == ($past(s.mem[ind_idx]) == 8'h00);
    endproperty
    a_ind_load: assert property (p_ind_load) // RULE6 RULE11
        else $error("indirect load value or zero wrong");

    property p_ptr_inc;
        exec && op == shift_move_indirect_pkg::INDIRECT_LOAD_OP &&
            !relative && !mode[0] |=>
            s.ptr[$past(ptr_sel)] == $past(s.ptr[ptr_sel]) + 16'h0001;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) // RULE7 RULE12
        else $error("pointer not incremented");

    property p_ptr_dec;
        exec && op == shift_move_indirect_pkg::INDIRECT_LOAD_OP &&
            !relative && mode[0] |=>
            s.ptr[$past(ptr_sel)] == $past(s.ptr[ptr_sel]) - 16'h0001;
    endproperty
    a_ptr_dec: assert property (p_ptr_dec) // RULE7 RULE8
        else $error("pointer not decremented");

    property p_ptr_rel;
        exec && op == shift_move_indirect_pkg::INDIRECT_LOAD_OP && relative
            |=> $stable(s.ptr);
    endproperty
    a_ptr_rel: assert property (p_ptr_rel) // RULE7
        else $error("pointer moved on relative load");

    property p_flags_kept;
        exec && op == shift_move_indirect_pkg::INDIRECT_LOAD_OP |=>
            $stable(s.carry) && s.ptr[!$past(ptr_sel)] ==
            $past(s.ptr[!ptr_sel]);
    endproperty
    a_flags_kept: assert property (p_flags_kept) // RULE13
        else $error("carry or other pointer disturbed");

    c_shift: cover property (exec &&
        op == shift_move_indirect_pkg::LOGICAL_SHIFT_RIGHT_OP && dest_file);
    c_wrap: cover property (exec && !relative &&
        op == shift_move_indirect_pkg::INDIRECT_LOAD_OP &&
        s.ptr[ptr_sel] == 16'hFFFF && !mode[0]);
    c_window: cover property (exec &&
        op == shift_move_indirect_pkg::FILE_MOVE_OP &&
        file_addr == shift_move_indirect_pkg::WINDOW1_FILE);
endmodule // shift_move_indirect_exec

// File: dv/shift_move_indirect_exec_tb.sv
// self-checking testbench for the shift, move and indirect-load unit
module shift_move_indirect_exec_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================================
    // signals and design
    logic clk_in;
    logic rst_n_in;
    logic ce_in;
    logic psel_in;
    logic penable_in;
    logic pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [7:0] acc_out;
    logic carry_out;
    logic zero_out;
    int err_count = 0;
    int tests_run = 0;

    typedef struct {
        logic [31:0] cmd;
        logic [7:0] acc;
        logic c;
        logic z;
        logic [15:0] p0;
        logic [15:0] p1;
    } row_t;
    row_t rows[16];
    int nr = 0;
    logic [31:0] rd;
    logic er;

    localparam logic [1:0] SHR =
        shift_move_indirect_pkg::LOGICAL_SHIFT_RIGHT_OP;
    localparam logic [1:0] MOV = shift_move_indirect_pkg::FILE_MOVE_OP;
    localparam logic [11:0] CMD = shift_move_indirect_pkg::CMD_OFFSET;
    localparam logic [11:0] MEM = shift_move_indirect_pkg::MEM_BASE;

    shift_move_indirect_exec #(.DEPTH(64)) uut (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .acc_out(acc_out),
        .carry_out(carry_out),
        .zero_out(zero_out)
    );

    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end

    // ========================================================
    // bus cycles and comparisons
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'h1;
        penable_in <= 1'h0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'h1;
        // wait count is bounded so a dead slave cannot hang the run
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'h1 && n < 50);
        if (n >= 50) begin
            err_count++;
            $display("mismatch at %0t: no pready", $time);
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic sm(input logic [1:0] op, input logic [6:0] f,
            input logic d);
        rows[nr].cmd = {22'h0, op, d, f};
    endtask

    task automatic ind(input logic [1:0] m, input logic s, input logic r,
            input logic [5:0] o);
        rows[nr].cmd = {12'h0, o, r, s, m, 2'h3, 8'h00};
    endtask

    task automatic res(input logic [7:0] acc, input logic c,
            input logic z, input logic [15:0] p0, input logic [15:0] p1);
        rows[nr].acc = acc;
        rows[nr].c = c;
        rows[nr].z = z;
        rows[nr].p0 = p0;
        rows[nr].p1 = p1;
        nr++;
    endtask

    task automatic wrap_up;
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end

    // ========================================================
    // main sequence
    initial begin
        rst_n_in = 1'h0;
        ce_in = 1'h1;
        psel_in = 1'h0;
        penable_in = 1'h0;
        pwrite_in = 1'h0;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        // memory starts as mem[i] = i, pointer1 at 20h, pointer0 at 0
        // modes: 0 pre-inc, 1 pre-dec, 2 post-inc, 3 post-dec
        sm(SHR, 7'h05, 1'h0);
        res(8'h02, 1'h1, 1'h0, 16'h0000, 16'h0020);
        sm(SHR, 7'h01, 1'h0);
        res(8'h10, 1'h0, 1'h0, 16'h0000, 16'h0020);
        sm(SHR, 7'h03, 1'h1);
        res(8'h10, 1'h1, 1'h0, 16'h0000, 16'h0020);
        sm(SHR, 7'h03, 1'h1);
        res(8'h10, 1'h1, 1'h1, 16'h0000, 16'h0020);
        sm(MOV, 7'h03, 1'h1);
        res(8'h10, 1'h1, 1'h1, 16'h0000, 16'h0020);
        sm(MOV, 7'h07, 1'h0);
        res(8'h07, 1'h1, 1'h0, 16'h0000, 16'h0020);
        sm(MOV, 7'h00, 1'h0);
        res(8'h00, 1'h1, 1'h1, 16'h0000, 16'h0020);
        ind(2'h1, 1'h0, 1'h0, 6'h00);
        res(8'h3F, 1'h1, 1'h0, 16'hFFFF, 16'h0020);
        ind(2'h2, 1'h0, 1'h0, 6'h00);
        res(8'h3F, 1'h1, 1'h0, 16'h0000, 16'h0020);
        ind(2'h2, 1'h0, 1'h0, 6'h00);
        res(8'h00, 1'h1, 1'h1, 16'h0001, 16'h0020);
        ind(2'h0, 1'h1, 1'h0, 6'h00);
        res(8'h21, 1'h1, 1'h0, 16'h0001, 16'h0021);
        ind(2'h3, 1'h1, 1'h0, 6'h00);
        res(8'h21, 1'h1, 1'h0, 16'h0001, 16'h0020);
        ind(2'h2, 1'h1, 1'h1, 6'h20);
        res(8'h00, 1'h1, 1'h1, 16'h0001, 16'h0020);
        ind(2'h0, 1'h1, 1'h1, 6'h1F);
        res(8'h3F, 1'h1, 1'h0, 16'h0001, 16'h0020);
        ind(2'h0, 1'h0, 1'h0, 6'h00);
        res(8'h02, 1'h1, 1'h0, 16'h0002, 16'h0020);
        ind(2'h1, 1'h0, 1'h0, 6'h00);
        res(8'h01, 1'h1, 1'h0, 16'h0001, 16'h0020);
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'h1;
        rdchk(shift_move_indirect_pkg::STATUS_OFFSET, 32'h0);
        chk({24'h0, acc_out}, 32'h0);
        for (int i = 0; i < 64; i++) begin
            apb(1'h1, MEM + 12'(4 * i), 32'(i));
        end
        apb(1'h1, shift_move_indirect_pkg::PTR1_OFFSET, 32'h20);
        for (int i = 0; i < nr; i++) begin
            apb(1'h1, CMD, rows[i].cmd);
            @(negedge clk_in);
            chk({24'h0, acc_out}, {24'h0, rows[i].acc});
            chk({30'h0, zero_out, carry_out}, {30'h0, rows[i].z, rows[i].c});
            rdchk(shift_move_indirect_pkg::PTR0_OFFSET, {16'h0, rows[i].p0});
            rdchk(shift_move_indirect_pkg::PTR1_OFFSET, {16'h0, rows[i].p1});
        end
        // ====================================================
        // write-back, window, refusal and reset cases
        rdchk(MEM + 12'h00C, 32'h0);
        apb(1'h1, CMD, {22'h0, SHR, 1'h1, 7'h00});
        @(negedge clk_in);
        chk({24'h0, acc_out}, 32'h01);
        rdchk(MEM + 12'h004, 32'h0);
        rdchk(shift_move_indirect_pkg::STATUS_OFFSET, 32'h3);
        rdchk(12'h020, 32'h0);
        chk({31'h0, er}, 32'h1);
        rdchk(shift_move_indirect_pkg::ACC_OFFSET, 32'h01);
        chk({31'h0, er}, 32'h0);
        // a reset in mid-run must clear pointer1, the accumulator and the flags again
        @(posedge clk_in);
        rst_n_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'h1;
        @(negedge clk_in);
        chk({22'h0, acc_out, carry_out, zero_out}, 32'h0);
        rdchk(shift_move_indirect_pkg::PTR1_OFFSET, 32'h0);
        wrap_up();
    end

endmodule // shift_move_indirect_exec_tb
